// [inc/cfs_irq_if.sv]
/*
 * Interrupt decision carrier between the status word logic and the gate.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface cfs_irq_if;
    logic req;
    logic maskable;
    logic [cfs_pkg::PRIO_W-1:0] prio;
    logic [cfs_pkg::PRIO_W-1:0] level;
    logic igate;
    logic accept;

    modport gate (
        input req,
        input maskable,
        input prio,
        input level,
        input igate,
        output accept
    );
    modport core (
        output req,
        output maskable,
        output prio,
        output level,
        output igate,
        input accept
    );
endinterface

// [inc/cfs_pkg.sv]
/*
 * Shared constants and types for the processor status word and stack
 * pointer block. Assumes a 16-bit core datapath and a plain register port.
 */
package cfs_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int PSW_W = 11;
    localparam int PRIO_W = 3;
    localparam int VEC_W = 6;

    // Bit positions inside the status word.
    localparam int PSW_CARRY = 0;
    localparam int PSW_TRACE = 1;
    localparam int PSW_ZERO = 2;
    localparam int PSW_SIGN = 3;
    localparam int PSW_BANK = 4;
    localparam int PSW_OVF = 5;
    localparam int PSW_IGATE = 6;
    localparam int PSW_STKSEL = 7;
    localparam int PSW_PRIO_LO = 8;
    localparam int PSW_PRIO_HI = 10;

    // Register offsets on the register port.
    localparam logic [ADDR_W-1:0] OFS_PSW = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_USP = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ISP = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SB = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_ACTSP = 4'h4;

    // Values after reset.
    localparam logic [PSW_W-1:0] RST_PSW = 11'h000;
    localparam logic [DATA_W-1:0] RST_PTR = 16'h0000;

    // Highest trap vector that switches to the interrupt stack.
    localparam logic [VEC_W-1:0] TRAP_STKSEL_MAX = 6'h1F;

    typedef struct packed {
        logic [PSW_W-1:0] psw;
        logic [DATA_W-1:0] user_stack_pointer;
        logic [DATA_W-1:0] interrupt_stack_pointer;
        logic [DATA_W-1:0] sb;
        logic [DATA_W-1:0] active_sp;
        logic [DATA_W-1:0] rdata;
        logic accept;
    } cfs_state_s;
endpackage

// [sim/cfs_irq_model.sv]
/*
 * Interrupt controller model facing the status word block.
 * Assumes the bench raises HOLD to request and lowers it when done.
 */
`timescale 1ns/1ns
module cfs_irq_model (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Bench control
    input wire logic HOLD,
    input wire logic MASK_IN,
    input wire logic [cfs_pkg::PRIO_W-1:0] PRIO_IN,
    // Core side
    input wire logic IRQ_ACCEPT,
    output logic IRQ_REQ,
    output logic IRQ_MASKABLE,
    output logic [cfs_pkg::PRIO_W-1:0] IRQ_PRIO
);
    logic done_r;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            IRQ_REQ <= 1'h0;
            IRQ_MASKABLE <= 1'h0;
            IRQ_PRIO <= 3'h0;
            done_r <= 1'h0;
        end else if (HOLD && !done_r && !IRQ_ACCEPT) begin
            IRQ_REQ <= 1'h1;
            IRQ_MASKABLE <= MASK_IN;
            IRQ_PRIO <= PRIO_IN;
        end else begin
            // Idle qualifiers toggle so a stale value never looks valid.
            IRQ_REQ <= 1'h0;
            IRQ_MASKABLE <= ~IRQ_MASKABLE;
            IRQ_PRIO <= ~IRQ_PRIO;
            done_r <= HOLD && (done_r || IRQ_ACCEPT);
        end
    end
endmodule

// [sim/cpu_flag_stack_select_tb.sv]
/*
 * Self-checking bench for the status word and stack pointer block.
 * Assumes the register map and pulse contract of the design notes.
 */
`timescale 1ns/1ns
module cpu_flag_stack_select_tb;
    logic clock, resetn, reg_wr, reg_rd, alu_upd, alu_carry, alu_ovf, sp_push, sp_pop;
    logic trap_exec, irq_req, irq_mask, irq_accept, bank_sel, hold, mask_in;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, alu_result, active_sp, static_base;
    logic [5:0] trap_vec;
    logic [2:0] irq_prio, prio_in;
    logic [10:0] psw_out;
    int fails = 0;
    int tests_run = 0;

    cfs_core uut (.CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .ALU_UPD(alu_upd), .ALU_RESULT(alu_result), .ALU_CARRY(alu_carry),
        .ALU_OVF(alu_ovf), .SP_PUSH(sp_push), .SP_POP(sp_pop), .TRAP_EXEC(trap_exec),
        .TRAP_VEC(trap_vec), .IRQ_REQ(irq_req), .IRQ_MASKABLE(irq_mask),
        .IRQ_PRIO(irq_prio), .IRQ_ACCEPT(irq_accept), .PSW_OUT(psw_out),
        .ACTIVE_SP(active_sp), .STATIC_BASE(static_base), .BANK_SEL(bank_sel));
    cfs_irq_model far (.CLOCK(clock), .RESETN(resetn), .HOLD(hold), .MASK_IN(mask_in),
        .PRIO_IN(prio_in), .IRQ_ACCEPT(irq_accept), .IRQ_REQ(irq_req),
        .IRQ_MASKABLE(irq_mask), .IRQ_PRIO(irq_prio));

    always #10 clock = ~clock;

    task report_and_stop();
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'h0;
        @(negedge clock);
    endtask

    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'h0;
        @(negedge clock);
        chk("reg_rdata", reg_rdata, e);
    endtask

    task stk(input logic pu, input logic po, input logic [15:0] e);
        @(posedge clock);
        sp_push <= pu;
        sp_pop <= po;
        @(posedge clock);
        sp_push <= 1'h0;
        sp_pop <= 1'h0;
        @(negedge clock);
        chk("active_sp", active_sp, e);
    endtask

    task trap(input logic [5:0] v, input logic [1:0] e);
        @(posedge clock);
        trap_exec <= 1'h1;
        trap_vec <= v;
        @(posedge clock);
        trap_exec <= 1'h0;
        @(negedge clock);
        chk("choice_gate", {14'h0000, psw_out[7:6]}, {14'h0000, e});
    endtask

    task irq(input logic m, input logic [2:0] p, input logic e);
        logic seen;
        seen = 1'h0;
        @(posedge clock);
        hold <= 1'h1;
        mask_in <= m;
        prio_in <= p;
        repeat (6) begin
            @(negedge clock);
            if (irq_accept === 1'h1) seen = 1'h1;
        end
        @(posedge clock);
        hold <= 1'h0;
        repeat (2) @(posedge clock);
        chk("irq_accept", {15'h0000, seen}, {15'h0000, e});
    endtask

    initial begin
        clock = 0;
        {resetn, reg_wr, reg_rd, alu_upd, alu_carry, alu_ovf, sp_push, sp_pop} = 8'h00;
        {trap_exec, hold, mask_in, reg_addr, reg_wdata, alu_result, trap_vec, prio_in} =
            48'h000000000000;
        repeat (20) @(posedge clock);
        resetn <= 1'h1;
        @(negedge clock);
        chk("psw_out", {5'h00, psw_out}, 16'h0000);
        wr(4'h1, 16'h1234);
        wr(4'h2, 16'h5678);
        wr(4'h3, 16'h9ABC);
        rd(4'h1, 16'h1234);
        rd(4'h2, 16'h5678);
        rd(4'h3, 16'h9ABC);
        chk("static_base", static_base, 16'h9ABC);
        rd(4'hF, 16'h0000);
        // Trace and reserved bits are written as zero.
        wr(4'h0, 16'h07FD);
        rd(4'h0, 16'h07FD);
        chk("active_sp", active_sp, 16'h1234);
        chk("bank_sel", {15'h0000, bank_sel}, 16'h0001);
        // The active pointer index is read only; the write must be ignored.
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h1234);
        stk(1'h1, 1'h0, 16'h1232);
        rd(4'h2, 16'h5678);
        stk(1'h1, 1'h1, 16'h1232);
        stk(1'h0, 1'h1, 16'h1234);
        wr(4'h0, 16'h0000);
        chk("active_sp", active_sp, 16'h5678);
        chk("bank_sel", {15'h0000, bank_sel}, 16'h0000);
        rd(4'h4, 16'h5678);
        stk(1'h1, 1'h0, 16'h5676);
        rd(4'h1, 16'h1234);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            alu_upd <= 1'h1;
            alu_result <= (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : 16'h0001;
            alu_carry <= (i != 1);
            alu_ovf <= (i != 0);
            @(posedge clock);
            alu_upd <= 1'h0;
            @(negedge clock);
            chk("flags", {12'h000, psw_out[5], psw_out[3:2], psw_out[0]},
                (i == 0) ? 16'h3 : (i == 1) ? 16'hC : 16'h9);
        end
        wr(4'h0, 16'h00C0);
        trap(6'h1F, 2'h0);
        wr(4'h0, 16'h00C0);
        trap(6'h20, 2'h2);
        wr(4'h0, 16'h01C0);
        irq(1'h1, 3'h1, 1'h0);
        irq(1'h1, 3'h2, 1'h1);
        chk("choice_gate", {14'h0000, psw_out[7:6]}, 16'h0000);
        irq(1'h1, 3'h7, 1'h0);
        irq(1'h0, 3'h7, 1'h1);
        wr(4'h0, 16'h0740);
        irq(1'h0, 3'h7, 1'h0);
        report_and_stop();
    end

    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule

// [src/cfs_core.sv]
/*
 * Processor status word, dual stack pointers and static base register.
 * Assumes the ALU and sequencer drive one-cycle pulses synchronous to CLOCK, the interrupt
 * controller holds its request until acknowledged, and software uses the plain register port.
 */
// Decided for this implementation: the plain strobed port and the placing of the registers.
// What this block does
// - Two 16-bit stack pointers, user and interrupt.
// - Choice bit 0 interrupt, 1 user pointer.
// - Interrupt acknowledge or trap 0-31 clears choice.
// - Hold 16-bit static base for relative addressing.
// - Status word is 11 bits wide.
// - Carry bit captures ALU carry, borrow, shift-out.
// - Null flag set exactly on zero result.
// - Negative flag set exactly on negative result.
// - Bank select bit picks register bank.
// - Range flag follows operation overflow.
// - Gate bit 0 blocks maskable requests.
// - Acknowledge clears the maskable gate bit.
// - Priority level is 3 bits, 0 to 7.
// - Accept only strictly higher priority requests.
// - Reserved status bits written 0, read as zero.
`timescale 1ns/1ns
module cfs_core #(
    parameter logic [15:0] SP_STEP = 16'h0002
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Register port
    input wire logic [cfs_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [cfs_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [cfs_pkg::DATA_W-1:0] REG_RDATA,
    // ALU result flags
    input wire logic ALU_UPD,
    input wire logic [cfs_pkg::DATA_W-1:0] ALU_RESULT,
    input wire logic ALU_CARRY,
    input wire logic ALU_OVF,
    // Stack operations
    input wire logic SP_PUSH,
    input wire logic SP_POP,
    // Software trap
    input wire logic TRAP_EXEC,
    input wire logic [cfs_pkg::VEC_W-1:0] TRAP_VEC,
    // Interrupt request path
    input wire logic IRQ_REQ,
    input wire logic IRQ_MASKABLE,
    input wire logic [cfs_pkg::PRIO_W-1:0] IRQ_PRIO,
    output logic IRQ_ACCEPT,
    // Core state outputs
    output logic [cfs_pkg::PSW_W-1:0] PSW_OUT,
    output logic [cfs_pkg::DATA_W-1:0] ACTIVE_SP,
    output logic [cfs_pkg::DATA_W-1:0] STATIC_BASE,
    output logic BANK_SEL
);
    cfs_pkg::cfs_state_s st_r;
    cfs_pkg::cfs_state_s st_nxt;
    logic stk_step;

    cfs_irq_if irq ();

    // A request is held off during the acknowledge cycle so that a
    // requester that drops late is not accepted twice.
    always_comb begin
        irq.req = IRQ_REQ && !st_r.accept;
        irq.maskable = IRQ_MASKABLE;
        irq.prio = IRQ_PRIO;
        irq.level = st_r.psw[cfs_pkg::PSW_PRIO_HI:cfs_pkg::PSW_PRIO_LO];
        irq.igate = st_r.psw[cfs_pkg::PSW_IGATE];
    end

    cfs_irq_gate u_gate (
        .irq(irq)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;
        st_nxt.accept = irq.accept;
        stk_step = SP_PUSH ^ SP_POP;

        // Software writes come first so that hardware events in the same
        // cycle override them.
        if (REG_WR) begin
            unique case (REG_ADDR)
                cfs_pkg::OFS_PSW: begin
                    // The trace bit is stored as written; keeping it zero
                    // is the software's duty.
                    st_nxt.psw = REG_WDATA[cfs_pkg::PSW_W-1:0];
                end
                cfs_pkg::OFS_USP: begin
                    st_nxt.user_stack_pointer = REG_WDATA;
                end
                cfs_pkg::OFS_ISP: begin
                    st_nxt.interrupt_stack_pointer = REG_WDATA;
                end
                cfs_pkg::OFS_SB: begin
                    st_nxt.sb = REG_WDATA;
                end
                default: begin
                end
            endcase
        end

        if (ALU_UPD) begin
            st_nxt.psw[cfs_pkg::PSW_CARRY] = ALU_CARRY;
            st_nxt.psw[cfs_pkg::PSW_ZERO] = (ALU_RESULT == 16'h0000);
            st_nxt.psw[cfs_pkg::PSW_SIGN] = ALU_RESULT[cfs_pkg::DATA_W-1];
            st_nxt.psw[cfs_pkg::PSW_OVF] = ALU_OVF;
        end

        // Only the pointer selected now moves; push and pop together cancel.
        if (stk_step) begin
            if (st_r.psw[cfs_pkg::PSW_STKSEL]) begin
                st_nxt.user_stack_pointer = SP_PUSH ? st_r.user_stack_pointer - SP_STEP : st_r.user_stack_pointer + SP_STEP;
            end else begin
                st_nxt.interrupt_stack_pointer = SP_PUSH ? st_r.interrupt_stack_pointer - SP_STEP : st_r.interrupt_stack_pointer + SP_STEP;
            end
        end

        if (irq.accept) begin
            st_nxt.psw[cfs_pkg::PSW_IGATE] = 1'b0;
            st_nxt.psw[cfs_pkg::PSW_STKSEL] = 1'b0;
        end

        if (TRAP_EXEC) begin
            st_nxt.psw[cfs_pkg::PSW_IGATE] = 1'b0;
            if (TRAP_VEC <= cfs_pkg::TRAP_STKSEL_MAX) begin
                st_nxt.psw[cfs_pkg::PSW_STKSEL] = 1'b0;
            end
        end

        st_nxt.active_sp = st_nxt.psw[cfs_pkg::PSW_STKSEL] ? st_nxt.user_stack_pointer : st_nxt.interrupt_stack_pointer;

        if (REG_RD) begin
            unique case (REG_ADDR)
                cfs_pkg::OFS_PSW: begin
                    // The five reserved bits above the word read as zero.
                    st_nxt.rdata = {5'h00, st_r.psw};
                end
                cfs_pkg::OFS_USP: begin
                    st_nxt.rdata = st_r.user_stack_pointer;
                end
                cfs_pkg::OFS_ISP: begin
                    st_nxt.rdata = st_r.interrupt_stack_pointer;
                end
                cfs_pkg::OFS_SB: begin
                    st_nxt.rdata = st_r.sb;
                end
                cfs_pkg::OFS_ACTSP: begin
                    st_nxt.rdata = st_r.active_sp;
                end
                default: begin
                    st_nxt.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            st_r.psw <= cfs_pkg::RST_PSW;
            st_r.user_stack_pointer <= cfs_pkg::RST_PTR;
            st_r.interrupt_stack_pointer <= cfs_pkg::RST_PTR;
            st_r.sb <= cfs_pkg::RST_PTR;
            st_r.active_sp <= cfs_pkg::RST_PTR;
            st_r.rdata <= 16'h0000;
            st_r.accept <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA = st_r.rdata;
    assign IRQ_ACCEPT = st_r.accept;
    assign PSW_OUT = st_r.psw;
    assign ACTIVE_SP = st_r.active_sp;
    assign STATIC_BASE = st_r.sb;
    assign BANK_SEL = st_r.psw[cfs_pkg::PSW_BANK];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    a_active_sp_sel: assert property (
        ACTIVE_SP == (PSW_OUT[cfs_pkg::PSW_STKSEL] ? st_r.user_stack_pointer : st_r.interrupt_stack_pointer)
    ) else $error("active pointer does not follow choice bit");

    a_ack_clears_flags: assert property (
        irq.accept |=> IRQ_ACCEPT && !PSW_OUT[cfs_pkg::PSW_IGATE]
    ) else $error("acknowledge did not clear gate bit");

    a_ack_stack_isp: assert property (
        irq.accept |=> !PSW_OUT[cfs_pkg::PSW_STKSEL] && ACTIVE_SP == st_r.interrupt_stack_pointer
    ) else $error("acknowledge did not select interrupt stack");

    a_trap_low_vec: assert property (
        TRAP_EXEC && TRAP_VEC <= 6'h1F |=> !PSW_OUT[cfs_pkg::PSW_STKSEL]
    ) else $error("low trap vector kept user stack");

    a_trap_high_vec: assert property (
        TRAP_EXEC && TRAP_VEC > 6'h1F && !REG_WR && !irq.accept
        |=> $stable(PSW_OUT[cfs_pkg::PSW_STKSEL])
    ) else $error("high trap vector changed stack choice");

    a_null_flag: assert property (
        ALU_UPD |=> PSW_OUT[cfs_pkg::PSW_ZERO] == ($past(ALU_RESULT) == 16'h0000)
    ) else $error("null flag wrong after update");

    a_sign_carry_ovf: assert property (
        ALU_UPD |=> PSW_OUT[cfs_pkg::PSW_SIGN] == $past(ALU_RESULT[15])
            && PSW_OUT[cfs_pkg::PSW_CARRY] == $past(ALU_CARRY)
            && PSW_OUT[cfs_pkg::PSW_OVF] == $past(ALU_OVF)
    ) else $error("sign, carry or overflow flag wrong");

    a_mask_blocks: assert property (
        IRQ_MASKABLE && !PSW_OUT[cfs_pkg::PSW_IGATE] |-> !irq.accept
    ) else $error("maskable request accepted with gate closed");

    a_prio_strict: assert property (
        irq.accept |-> IRQ_PRIO > PSW_OUT[cfs_pkg::PSW_PRIO_HI:cfs_pkg::PSW_PRIO_LO]
    ) else $error("request accepted without higher priority");

    a_push_user_only: assert property (
        SP_PUSH && !SP_POP && !REG_WR && PSW_OUT[cfs_pkg::PSW_STKSEL]
        |=> st_r.user_stack_pointer == $past(st_r.user_stack_pointer) - SP_STEP && $stable(st_r.interrupt_stack_pointer)
    ) else $error("user push moved wrong pointer");

    a_reserved_zero: assert property (
        REG_RD && REG_ADDR == cfs_pkg::OFS_PSW |=> REG_RDATA[15:11] == 5'h00
    ) else $error("reserved status bits not zero");

    a_rdata_idle: assert property (
        !REG_RD |=> REG_RDATA == 16'h0000
    ) else $error("read data outside read answer cycle");

    a_write_usp: assert property (
        REG_WR && REG_ADDR == cfs_pkg::OFS_USP && !SP_PUSH && !SP_POP
        |=> st_r.user_stack_pointer == $past(REG_WDATA)
    ) else $error("user pointer write did not land");

    a_write_isp: assert property (
        REG_WR && REG_ADDR == cfs_pkg::OFS_ISP && !SP_PUSH && !SP_POP
        |=> st_r.interrupt_stack_pointer == $past(REG_WDATA)
    ) else $error("interrupt pointer write did not land");

    a_base_write: assert property (
        REG_WR && REG_ADDR == cfs_pkg::OFS_SB |=> STATIC_BASE == $past(REG_WDATA)
    ) else $error("static base write did not land");

    a_base_holds: assert property (
        !(REG_WR && REG_ADDR == cfs_pkg::OFS_SB) |=> $stable(STATIC_BASE)
    ) else $error("static base changed without a write");

    a_bank_write: assert property (
        REG_WR && REG_ADDR == cfs_pkg::OFS_PSW |=> BANK_SEL == $past(REG_WDATA[4])
    ) else $error("bank select does not follow written bit");

    a_psw_write: assert property (
        REG_WR && REG_ADDR == cfs_pkg::OFS_PSW && !ALU_UPD && !TRAP_EXEC && !irq.accept
        |=> PSW_OUT == $past(REG_WDATA[cfs_pkg::PSW_W-1:0])
    ) else $error("status word write did not land");

    a_pop_isp_only: assert property (
        SP_POP && !SP_PUSH && !REG_WR && !PSW_OUT[cfs_pkg::PSW_STKSEL]
        |=> st_r.interrupt_stack_pointer == $past(st_r.interrupt_stack_pointer) + SP_STEP && $stable(st_r.user_stack_pointer)
    ) else $error("interrupt pop moved wrong pointer");

    a_push_pop_cancel: assert property (
        SP_PUSH && SP_POP && !REG_WR |=> $stable(st_r.user_stack_pointer) && $stable(st_r.interrupt_stack_pointer)
    ) else $error("push with pop moved a pointer");

    a_ack_keeps_level: assert property (
        irq.accept && !REG_WR |=> $stable(PSW_OUT[cfs_pkg::PSW_PRIO_HI:cfs_pkg::PSW_PRIO_LO])
    ) else $error("acknowledge changed priority level");

    a_trap_gate: assert property (
        TRAP_EXEC |=> !PSW_OUT[cfs_pkg::PSW_IGATE]
    ) else $error("trap did not close the gate bit");

    a_flags_hold: assert property (
        !ALU_UPD && !REG_WR |=> $stable(PSW_OUT[cfs_pkg::PSW_CARRY])
            && $stable(PSW_OUT[cfs_pkg::PSW_ZERO])
    ) else $error("result flags changed without an update");

    a_accept_pulse: assert property (
        IRQ_ACCEPT |=> !IRQ_ACCEPT
    ) else $error("acknowledge pulse longer than one cycle");

    c_maskable_accept: cover property (
        IRQ_MASKABLE && irq.accept ##1 IRQ_ACCEPT
    );
    c_trap_low: cover property (
        TRAP_EXEC && TRAP_VEC <= 6'h1F && PSW_OUT[cfs_pkg::PSW_STKSEL]
    );
    c_push_then_pop: cover property (
        SP_PUSH && !SP_POP ##1 SP_POP && !SP_PUSH
    );
    c_nonmask_accept: cover property (
        !IRQ_MASKABLE && irq.accept
    );
    c_alu_zero: cover property (
        ALU_UPD && ALU_RESULT == 16'h0000
    );
endmodule

// [src/cfs_irq_gate.sv]
/*
 * Interrupt acceptance decision: priority compare and maskable gating.
 * Assumes the request is already qualified against a pending acknowledge.
 */
`timescale 1ns/1ns
module cfs_irq_gate (
    // Decision carrier
    cfs_irq_if.gate irq
);
    logic prio_ok;
    logic mask_ok;

    always_comb begin
        prio_ok = irq.prio > irq.level;
        mask_ok = !irq.maskable || irq.igate;
        irq.accept = irq.req && prio_ok && mask_ok;
    end
endmodule
